// *** dv/lda_master.sv ***
`timescale 1ns/1ns
`default_nettype none
// ********************************************************
// bus master on the two-wire link, 800 ns bit time
// ********************************************************
module lda_master (
  input wire logic sda_oe, // device pulls data low
  input wire logic sda_out, // device drive level
  output logic scl, // serial clock, high between frames
  output logic sda_in // wired data level
);
  logic drv_low;
  // pull-up: a released line reads high
  assign sda_in = ~drv_low & (sda_oe ? sda_out : 1'h1);
  initial begin
    scl = 1'h1;
    drv_low = 1'h0;
  end
  // also serves as repeated start; waits out a device ack still held after the fall
  task automatic start;
    drv_low = 1'h0;
    #400 scl = 1'h1;
    #200 drv_low = 1'h1;
    #400 scl = 1'h0;
  endtask : start
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #200 drv_low = ~b[i];
      #200 scl = 1'h1;
      #400 scl = 1'h0;
    end
    #200 drv_low = 1'h0;
    #200 scl = 1'h1;
    #200 ack = ~sda_in;
    #200 scl = 1'h0;
  endtask : put_byte
  task automatic get_byte(input logic last, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #200 drv_low = 1'h0;
      #200 scl = 1'h1;
      #200 b[i] = sda_in;
      #200 scl = 1'h0;
    end
    #200 drv_low = ~last;
    #200 scl = 1'h1;
    #400 scl = 1'h0;
  endtask : get_byte
  task automatic stop;
    #200 drv_low = 1'h1;
    #200 scl = 1'h1;
    #400 drv_low = 1'h0;
    #400;
  endtask : stop
endmodule : lda_master
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", n, e, s); end end
module tb;
  import lda_pkg::*;
  typedef struct packed {
    logic [6:0] pin;
    logic [7:0] adr;
    logic aa;
    logic [7:0] ctl;
    logic ca;
    logic [1:0] n;
    logic [14:0] p;
  } lda_row_t;
  // ********************************************************
  // ordinary transfers: pins, address, acks, control, strobe pointers
  // ********************************************************
  localparam lda_row_t ROWS [21] = '{
    '{7'h55, 8'hE0, 1'h1, 8'h05, 1'h1, 2'h3, {5'h05, 5'h05, 5'h05}},
    '{7'h55, 8'hE1, 1'h1, 8'h00, 1'h0, 2'h2, {5'h05, 5'h05, 5'h00}},
    '{7'h55, 8'hE2, 1'h0, 8'h00, 1'h0, 2'h0, 15'h0000},
    '{7'h55, 8'hE3, 1'h0, 8'h00, 1'h0, 2'h0, 15'h0000},
    '{7'h55, 8'hE9, 1'h0, 8'h00, 1'h0, 2'h0, 15'h0000},
    '{7'h55, 8'h07, 1'h0, 8'h00, 1'h0, 2'h0, 15'h0000},
    '{7'h55, 8'h06, 1'h1, 8'h00, 1'h0, 2'h0, 15'h0000},
    '{7'h55, 8'hAA, 1'h1, 8'hB0, 1'h1, 2'h3, {5'h10, 5'h11, 5'h02}},
    '{7'h55, 8'hAA, 1'h1, 8'hD2, 1'h1, 2'h3, {5'h12, 5'h13, 5'h12}},
    '{7'h55, 8'hAA, 1'h1, 8'hF2, 1'h1, 2'h3, {5'h12, 5'h13, 5'h02}},
    '{7'h55, 8'hAB, 1'h1, 8'h00, 1'h0, 2'h3, {5'h03, 5'h04, 5'h05}},
    '{7'h55, 8'hAA, 1'h1, 8'h9C, 1'h0, 2'h0, 15'h0000},
    '{7'h55, 8'hAA, 1'h1, 8'h9A, 1'h1, 2'h3, {5'h1A, 5'h1B, 5'h00}},
    '{7'h55, 8'hE0, 1'h0, 8'h00, 1'h0, 2'h0, 15'h0000},
    '{7'h55, 8'h0E, 1'h1, 8'h85, 1'h1, 2'h1, {5'h05, 10'h000}},
    '{7'h55, 8'hE2, 1'h1, 8'h01, 1'h1, 2'h1, {5'h01, 10'h000}},
    '{7'h55, 8'hE5, 1'h1, 8'h00, 1'h0, 2'h1, {5'h01, 10'h000}},
    '{7'h78, 8'hF0, 1'h1, 8'h05, 1'h1, 2'h0, 15'h0000},
    '{7'h78, 8'hAA, 1'h0, 8'h00, 1'h0, 2'h0, 15'h0000},
    '{7'h01, 8'h02, 1'h1, 8'h05, 1'h1, 2'h0, 15'h0000},
    '{7'h01, 8'h80, 1'h0, 8'h00, 1'h0, 2'h0, 15'h0000}
  };
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic [6:0] addr_pin = 7'h55;
  logic scl, sda_in, sda_out, sda_oe, soft_call, rs_ack;
  logic [7:0] ctrl_byte, rd_data, rs_data;
  logic [3:0] addr_en;
  lda_reg_req_t reg_req;
  logic [4:0] seen [$];
  int sr_count = 0;
  int bad_count = 0;
  int comparisons = 0;
  always #50 core_clk = ~core_clk;
  // register file stand-in: data names its own pointer
  assign rd_data = {3'h5, ctrl_byte[4:0]};
  lda_master u_mst (.sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda_in(sda_in));
  lda_i2c_front u_dut (
    .CORE_CLK(core_clk), .RST(rst), .SCL(scl), .SDA_IN(sda_in), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .ADDR_PIN(addr_pin), .REG_REQ(reg_req), .REG_RD_DATA(rd_data),
    .CTRL_BYTE(ctrl_byte), .ADDR_EN(addr_en), .SOFT_RESET_CALL(soft_call)
  );
  // strobes are looked at mid-cycle, clear of the edge that launches them
  always @(negedge core_clk) begin
    if (reg_req.wr === 1'h1 || reg_req.rd === 1'h1) seen.push_back(reg_req.addr);
    if (reg_req.wr === 1'h1) `CHK("wdata", 8'h0F, reg_req.wdata)
    if (soft_call === 1'h1) sr_count++;
  end
  task automatic conclude;
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  task automatic chk_rst;
    `CHK("ctl rst", 8'h80, ctrl_byte)
    `CHK("en rst", 4'h1, addr_en)
    `CHK("idle rst", 20'h00000, {reg_req, sda_oe, soft_call})
  endtask : chk_rst
  task automatic run_row(input lda_row_t r);
    logic a;
    logic [7:0] d;
    @(negedge core_clk) addr_pin = r.pin;
    // pins pass a synchroniser before the next frame
    repeat (4) @(negedge core_clk);
    seen.delete();
    u_mst.start();
    u_mst.put_byte(r.adr, a);
    `CHK("addr ack", r.aa, a)
    if (a === 1'h1 && r.adr[0] === 1'h1) begin
      for (int i = 0; i < r.n; i++) begin
        u_mst.get_byte(i == r.n - 1, d);
        `CHK("rdata", {3'h5, r.p[14 - 5 * i -: 5]}, d)
      end
    end else if (a === 1'h1 && r.adr != 8'h06) begin
      u_mst.put_byte(r.ctl, a);
      `CHK("ctl ack", r.ca, a)
      for (int i = 0; i < r.n; i++) begin
        u_mst.put_byte(8'h0F, a);
        `CHK("data ack", 1'h1, a)
      end
    end
    u_mst.stop();
    repeat (4) @(negedge core_clk);
    `CHK("strobes", int'(r.n), seen.size())
    for (int i = 0; i < r.n && i < seen.size(); i++) begin
      `CHK("reg addr", r.p[14 - 5 * i -: 5], seen[i])
    end
    if (r.n != 2'h0 && r.adr[0] == 1'h0) `CHK("mode bits", r.ctl[7:5], ctrl_byte[7:5])
  endtask : run_row
  initial begin
    #3000000;
    bad_count++;
    conclude();
  end
  initial begin
    repeat (20) @(negedge core_clk);
    chk_rst();
    rst = 1'h0;
    repeat (4) @(negedge core_clk);
    foreach (ROWS[k]) run_row(ROWS[k]);
    `CHK("soft calls", 1, sr_count)
    `CHK("enables", 4'hF, addr_en)
    // ********************************************************
    // repeated start into a read, then reset in mid-run
    // ********************************************************
    @(negedge core_clk) addr_pin = 7'h55;
    repeat (4) @(negedge core_clk);
    u_mst.start();
    u_mst.put_byte(8'hAA, rs_ack);
    u_mst.put_byte(8'h85, rs_ack);
    u_mst.start();
    u_mst.put_byte(8'hAB, rs_ack);
    `CHK("rstart ack", 1'h1, rs_ack)
    u_mst.get_byte(1'h1, rs_data);
    `CHK("rstart data", 8'hA5, rs_data)
    u_mst.stop();
    `CHK("ptr step", 5'h06, ctrl_byte[4:0])
    // broadcast copy read back, then the read wraps into the register file
    u_mst.start();
    u_mst.put_byte(8'hAA, rs_ack);
    u_mst.put_byte(8'h9B, rs_ack);
    u_mst.start();
    u_mst.put_byte(8'hAB, rs_ack);
    u_mst.get_byte(1'h0, rs_data);
    `CHK("bcast read", 8'h0F, rs_data)
    u_mst.get_byte(1'h1, rs_data);
    `CHK("wrap read", 8'hA0, rs_data)
    u_mst.stop();
    @(negedge core_clk) rst = 1'h1;
    repeat (2) @(negedge core_clk);
    chk_rst();
    rst = 1'h0;
    repeat (4) @(negedge core_clk);
    run_row(lda_row_t'{7'h55, 8'hE0, 1'h1, 8'h05, 1'h1, 2'h1, {5'h05, 10'h000}});
    run_row(lda_row_t'{7'h55, 8'hE4, 1'h0, 8'h00, 1'h0, 2'h0, 15'h0000});
    conclude();
  end
endmodule : tb
`default_nettype wire

// *** logic/lda_consts.svh ***
`ifndef LDA_CONSTS_SVH
`define LDA_CONSTS_SVH
// ********************************************************
// address values and reset contents
// ********************************************************
`define LDA_BCAST_RST 8'hE0
`define LDA_GRP1_RST 8'hE2
`define LDA_GRP2_RST 8'hE4
`define LDA_GRP3_RST 8'hE8
`define LDA_EN_RST 4'h1
`define LDA_CTL_RST 8'h80
`define LDA_SOFT_RESET_CALL_ADDR 8'h06
`define LDA_DIR_BIT 0
// ********************************************************
// pointer values
// ********************************************************
`define LDA_PTR_ZERO 5'h00
`define LDA_PTR_LAST 5'h1B
`define LDA_PTR_BRIGHT_FIRST 5'h02
`define LDA_PTR_BRIGHT_LAST 5'h11
`define LDA_PTR_GCTL_FIRST 5'h12
`define LDA_PTR_GCTL_LAST 5'h13
`define LDA_PTR_ENABLES 5'h00
`define LDA_PTR_GRP1 5'h18
`define LDA_PTR_GRP2 5'h19
`define LDA_PTR_GRP3 5'h1A
`define LDA_PTR_BCAST 5'h1B
// ********************************************************
// control byte fields and increment codes
// ********************************************************
`define LDA_CTL_PTR 4:0
`define LDA_CTL_MODE 7:5
`define LDA_CTL_EN_BIT 7
`define LDA_MODE_ALL 3'h4
`define LDA_MODE_BRIGHT 3'h5
`define LDA_MODE_GCTL 3'h6
`define LDA_MODE_BOTH 3'h7
`define LDA_MODE_NONE 3'h0
// ********************************************************
// enable bit positions, as held in the mode byte
// ********************************************************
`define LDA_EN_BCAST 0
`define LDA_EN_GRP3 1
`define LDA_EN_GRP2 2
`define LDA_EN_GRP1 3
`define LDA_EN_FIELD 3:0
`define LDA_BITS_PER_BYTE 4'h8
`endif

// *** logic/lda_i2c_front.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "lda_consts.svh"
module lda_i2c_front (
  input wire logic CORE_CLK, // core clock
  input wire logic RST, // async reset, active high
  input wire logic SCL, // serial clock pin
  input wire logic SDA_IN, // serial data pin level
  output logic SDA_OUT, // serial data drive level
  output logic SDA_OE, // high while pulling the data line low
  input wire logic [6:0] ADDR_PIN, // address pins, addr_pin_bit6 down to addr_pin_bit0
  output lda_pkg::lda_reg_req_t REG_REQ, // access strobe towards the register file
  input wire logic [7:0] REG_RD_DATA, // register file data at CTRL_BYTE pointer
  output logic [7:0] CTRL_BYTE, // pointer/control register
  output logic [3:0] ADDR_EN, // broadcast and group enables
  output logic SOFT_RESET_CALL // pulse when soft reset call is acked
);
  import lda_pkg::*;

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic [6:0] pin_s1;
    logic [6:0] pin_s2;
    lda_state_t st;
    lda_state_t after;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic master_ack;
    logic sda_oe;
    logic [7:0] ctl;
    logic [7:0] bcast;
    logic [2:0][7:0] grp;
    logic [3:0] en;
    lda_reg_req_t req;
    logic soft_reset_call;
  } lda_front_t;

  lda_front_t s;
  lda_front_t next_s;
  logic [4:0] step_ptr;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic byte_done;
  logic [7:0] rd_byte;
  logic addr_hit;

  lda_ptr_step u_step (
    .ctl(s.ctl),
    .next_ptr(step_ptr)
  );

  // address bits 7..1 of a received byte against a stored address byte
  function automatic logic addr_eq(input logic [7:0] rx, input logic [7:0] ref_byte);
    addr_eq = (rx[7:1] == ref_byte[7:1]);
  endfunction : addr_eq

  assign scl_rise = s.scl_s2 & ~s.scl_s3;
  assign scl_fall = ~s.scl_s2 & s.scl_s3;
  assign start_seen = s.scl_s2 & s.scl_s3 & s.sda_s3 & ~s.sda_s2;
  assign stop_seen = s.scl_s2 & s.scl_s3 & ~s.sda_s3 & s.sda_s2;
  assign byte_done = scl_fall & (s.bitcnt == `LDA_BITS_PER_BYTE);

  // pins are matched bit for bit, reserved patterns included
  assign addr_hit = (s.shreg[7:1] == s.pin_s2) |
    (s.en[`LDA_EN_BCAST] & addr_eq(s.shreg, s.bcast)) |
    (s.en[`LDA_EN_GRP1] & addr_eq(s.shreg, s.grp[0])) |
    (s.en[`LDA_EN_GRP2] & addr_eq(s.shreg, s.grp[1])) |
    (s.en[`LDA_EN_GRP3] & addr_eq(s.shreg, s.grp[2]));

  // the address registers are served from the local copies
  always_comb begin
    case (s.ctl[`LDA_CTL_PTR])
      `LDA_PTR_GRP1: rd_byte = s.grp[0];
      `LDA_PTR_GRP2: rd_byte = s.grp[1];
      `LDA_PTR_GRP3: rd_byte = s.grp[2];
      `LDA_PTR_BCAST: rd_byte = s.bcast;
      default: rd_byte = REG_RD_DATA;
    endcase
  end

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    next_s = s;
    next_s.scl_s1 = SCL;
    next_s.scl_s2 = s.scl_s1;
    next_s.scl_s3 = s.scl_s2;
    next_s.sda_s1 = SDA_IN;
    next_s.sda_s2 = s.sda_s1;
    next_s.sda_s3 = s.sda_s2;
    next_s.pin_s1 = ADDR_PIN;
    next_s.pin_s2 = s.pin_s1;
    next_s.req.wr = 1'b0;
    next_s.req.rd = 1'b0;
    next_s.soft_reset_call = 1'b0;
    if (start_seen) begin
      next_s.st = LDA_ADDR;
      next_s.bitcnt = 4'h0;
      next_s.sda_oe = 1'b0;
    end else if (stop_seen) begin
      next_s.st = LDA_IDLE;
      next_s.sda_oe = 1'b0;
    end else begin
      case (s.st)
        LDA_IDLE: begin
          next_s.sda_oe = 1'b0;
        end
        LDA_ADDR, LDA_CTRL, LDA_WDATA: begin
          if (scl_rise && s.bitcnt != `LDA_BITS_PER_BYTE) begin
            next_s.shreg = {s.shreg[6:0], s.sda_s2};
            next_s.bitcnt = s.bitcnt + 4'h1;
          end else if (byte_done) begin
            next_s.bitcnt = 4'h0;
            next_s.st = LDA_IDLE;
            if (s.st == LDA_ADDR) begin
              if (s.shreg == `LDA_SOFT_RESET_CALL_ADDR) begin
                // write form only; the read form falls through to the ordinary address match below
                next_s.sda_oe = 1'b1;
                next_s.soft_reset_call = 1'b1;
                next_s.st = LDA_ACK;
                next_s.after = LDA_IDLE;
              end else if (addr_hit) begin
                next_s.sda_oe = 1'b1;
                next_s.st = LDA_ACK;
                next_s.after = s.shreg[0] ? LDA_RDATA : LDA_CTRL;
              end
            end else if (s.st == LDA_CTRL) begin
              if (s.shreg[`LDA_CTL_PTR] <= `LDA_PTR_LAST) begin
                next_s.ctl = s.shreg;
                next_s.sda_oe = 1'b1;
                next_s.st = LDA_ACK;
                next_s.after = LDA_WDATA;
              end
            end else begin
              next_s.req.addr = s.ctl[`LDA_CTL_PTR];
              next_s.req.wdata = s.shreg;
              next_s.req.wr = 1'b1;
              next_s.sda_oe = 1'b1;
              next_s.st = LDA_ACK;
              next_s.after = LDA_WDATA;
              if (s.ctl[`LDA_CTL_EN_BIT]) begin
                next_s.ctl[`LDA_CTL_PTR] = step_ptr;
              end
              case (s.ctl[`LDA_CTL_PTR])
                `LDA_PTR_ENABLES: next_s.en = s.shreg[`LDA_EN_FIELD];
                `LDA_PTR_GRP1: next_s.grp[0] = s.shreg;
                `LDA_PTR_GRP2: next_s.grp[1] = s.shreg;
                `LDA_PTR_GRP3: next_s.grp[2] = s.shreg;
                `LDA_PTR_BCAST: next_s.bcast = s.shreg;
                default: begin
                end
              endcase
            end
          end
        end
        LDA_ACK: begin
          if (scl_fall) begin
            next_s.sda_oe = 1'b0;
            next_s.st = s.after;
            if (s.after == LDA_RDATA) begin
              // first read byte comes from the pointer as it stands
              next_s.req.addr = s.ctl[`LDA_CTL_PTR];
              next_s.req.rd = 1'b1;
              next_s.sda_oe = ~rd_byte[7];
              next_s.shreg = {rd_byte[6:0], 1'b0};
              next_s.bitcnt = 4'h1;
              if (s.ctl[`LDA_CTL_EN_BIT]) begin
                next_s.ctl[`LDA_CTL_PTR] = step_ptr;
              end
            end
          end
        end
        LDA_RDATA: begin
          if (byte_done) begin
            next_s.sda_oe = 1'b0;
            next_s.st = LDA_RACK;
          end else if (scl_fall) begin
            next_s.sda_oe = ~s.shreg[7];
            next_s.shreg = {s.shreg[6:0], 1'b0};
            next_s.bitcnt = s.bitcnt + 4'h1;
          end
        end
        LDA_RACK: begin
          if (scl_rise) begin
            next_s.master_ack = ~s.sda_s2;
          end else if (scl_fall) begin
            // a nack from the master ends the read; wait for stop or start
            next_s.st = LDA_IDLE;
            if (s.master_ack) begin
              next_s.st = LDA_RDATA;
              next_s.req.addr = s.ctl[`LDA_CTL_PTR];
              next_s.req.rd = 1'b1;
              next_s.sda_oe = ~rd_byte[7];
              next_s.shreg = {rd_byte[6:0], 1'b0};
              next_s.bitcnt = 4'h1;
              if (s.ctl[`LDA_CTL_EN_BIT]) begin
                next_s.ctl[`LDA_CTL_PTR] = step_ptr;
              end
            end
          end
        end
        default: begin
          next_s.st = LDA_IDLE;
          next_s.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // ********************************************************
  // registers
  // ********************************************************
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      s <= '0;
      s.scl_s1 <= 1'b1;
      s.scl_s2 <= 1'b1;
      s.scl_s3 <= 1'b1;
      s.sda_s1 <= 1'b1;
      s.sda_s2 <= 1'b1;
      s.sda_s3 <= 1'b1;
      s.st <= LDA_IDLE;
      s.after <= LDA_IDLE;
      s.ctl <= `LDA_CTL_RST;
      s.bcast <= `LDA_BCAST_RST;
      s.grp[0] <= `LDA_GRP1_RST;
      s.grp[1] <= `LDA_GRP2_RST;
      s.grp[2] <= `LDA_GRP3_RST;
      s.en <= `LDA_EN_RST;
    end else begin
      s <= next_s;
    end
  end

  // open drain: the line is only ever pulled low
  assign SDA_OUT = 1'b0;
  assign SDA_OE = s.sda_oe;
  assign REG_REQ = s.req;
  assign CTRL_BYTE = s.ctl;
  assign ADDR_EN = s.en;
  assign SOFT_RESET_CALL = s.soft_reset_call;

  // ********************************************************
  // checks
  // ********************************************************
  chk_soft_reset_call_read_nack: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s.st == LDA_ADDR && byte_done && s.shreg == (`LDA_SOFT_RESET_CALL_ADDR | 8'h01) &&
     s.shreg[7:1] != s.pin_s2) |=> !s.sda_oe && !s.soft_reset_call)
    else $error("soft reset call acked for read");
  chk_group_off_nack: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s.st == LDA_ADDR && byte_done && s.en[`LDA_EN_GRP1] == 1'b0 &&
     s.en[`LDA_EN_GRP2] == 1'b0 && s.en[`LDA_EN_GRP3] == 1'b0 &&
     s.shreg[7:1] != s.pin_s2 && !addr_eq(s.shreg, s.bcast) &&
     s.shreg != `LDA_SOFT_RESET_CALL_ADDR) |=> !s.sda_oe)
    else $error("disabled address acked");
  chk_reset_addrs: assert property (@(posedge CORE_CLK)
    $fell(RST) |-> s.bcast == `LDA_BCAST_RST && s.en == `LDA_EN_RST &&
      s.grp[2] == `LDA_GRP3_RST)
    else $error("address registers not at reset values");
  chk_ptr_reserved: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s.st == LDA_CTRL && byte_done && s.shreg[`LDA_CTL_PTR] > `LDA_PTR_LAST)
      |=> !s.sda_oe ##1 s.ctl == $past(s.ctl, 2))
    else $error("reserved pointer accepted");
  chk_wrap_all: assert property (@(posedge CORE_CLK) disable iff (RST)
    ((s.req.wr || s.req.rd) && s.ctl[`LDA_CTL_MODE] == `LDA_MODE_ALL &&
     s.req.addr == `LDA_PTR_LAST) |-> s.ctl[`LDA_CTL_PTR] == `LDA_PTR_ZERO)
    else $error("all-register wrap wrong");
  chk_wrap_bright: assert property (@(posedge CORE_CLK) disable iff (RST)
    ((s.req.wr || s.req.rd) && s.ctl[`LDA_CTL_MODE] == `LDA_MODE_BRIGHT &&
     s.req.addr == `LDA_PTR_BRIGHT_LAST) |-> s.ctl[`LDA_CTL_PTR] == `LDA_PTR_BRIGHT_FIRST)
    else $error("brightness wrap wrong");
  chk_wrap_gctl: assert property (@(posedge CORE_CLK) disable iff (RST)
    ((s.req.wr || s.req.rd) && s.ctl[`LDA_CTL_MODE] >= `LDA_MODE_GCTL &&
     s.req.addr == `LDA_PTR_GCTL_LAST) |-> s.ctl[`LDA_CTL_PTR] ==
      (s.ctl[`LDA_CTL_MODE] == `LDA_MODE_BOTH ? `LDA_PTR_BRIGHT_FIRST : `LDA_PTR_GCTL_FIRST))
    else $error("group control wrap wrong");
  chk_ptr_fixed: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s.req.wr || s.req.rd) |-> s.ctl[`LDA_CTL_MODE] == $past(s.ctl[`LDA_CTL_MODE]) &&
      (s.ctl[`LDA_CTL_MODE] != `LDA_MODE_NONE || s.ctl[`LDA_CTL_PTR] == s.req.addr))
    else $error("pointer or code bits moved wrongly");
  chk_ctrl_store: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s.st == LDA_CTRL && byte_done && s.shreg[`LDA_CTL_PTR] <= `LDA_PTR_LAST)
      |=> s.ctl == $past(s.shreg) && s.sda_oe)
    else $error("control byte not stored");
  chk_pin_ack: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s.st == LDA_ADDR && byte_done && s.shreg[7:1] == s.pin_s2)
      |=> s.sda_oe && s.st == LDA_ACK)
    else $error("own address not acked");
  chk_bcast_ack: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s.st == LDA_ADDR && byte_done && s.en[`LDA_EN_BCAST] && addr_eq(s.shreg, s.bcast))
      |=> s.sda_oe && s.st == LDA_ACK)
    else $error("broadcast address not acked");
  chk_group_ack: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s.st == LDA_ADDR && byte_done && s.en[`LDA_EN_GRP2] && addr_eq(s.shreg, s.grp[1]))
      |=> s.sda_oe)
    else $error("enabled group address not acked");
  chk_dir_read: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s.st == LDA_ADDR && byte_done && s.shreg[`LDA_DIR_BIT] && s.shreg[7:1] == s.pin_s2)
      |=> s.after == LDA_RDATA)
    else $error("read form not taken as read");
  chk_dir_write: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s.st == LDA_ADDR && byte_done && !s.shreg[`LDA_DIR_BIT] && s.shreg[7:1] == s.pin_s2 &&
     s.shreg != `LDA_SOFT_RESET_CALL_ADDR) |=> s.after == LDA_CTRL)
    else $error("write form not taken as write");
  chk_step_one: assert property (@(posedge CORE_CLK) disable iff (RST)
    ((s.req.wr || s.req.rd) && s.ctl[`LDA_CTL_MODE] == `LDA_MODE_ALL &&
     s.req.addr != `LDA_PTR_LAST) |-> s.ctl[`LDA_CTL_PTR] == s.req.addr + 5'h01)
    else $error("pointer did not step by one");
  chk_reset_groups: assert property (@(posedge CORE_CLK)
    $fell(RST) |-> s.grp[0] == `LDA_GRP1_RST && s.grp[1] == `LDA_GRP2_RST &&
      s.en[`LDA_EN_GRP1] == 1'b0)
    else $error("group registers not at reset values");
  chk_data_ack: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s.st == LDA_WDATA && byte_done) |=> s.sda_oe && s.req.wr && !s.req.rd)
    else $error("data byte not acked and strobed");
endmodule : lda_i2c_front
`default_nettype wire

// *** logic/lda_pkg.sv ***
`default_nettype none
package lda_pkg;
  typedef enum logic [2:0] {
    LDA_IDLE, LDA_ADDR, LDA_CTRL, LDA_WDATA, LDA_ACK, LDA_RDATA, LDA_RACK
  } lda_state_t;

  // one access towards the register file
  typedef struct packed {
    logic [4:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } lda_reg_req_t;
endpackage : lda_pkg
`default_nettype wire

// *** logic/lda_ptr_step.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "lda_consts.svh"
module lda_ptr_step (
  input wire logic [7:0] ctl, // current control byte
  output logic [4:0] next_ptr // pointer after one data byte
);
  import lda_pkg::*;
  logic [4:0] ptr;
  logic [4:0] inc;

  always_comb begin
    ptr = ctl[`LDA_CTL_PTR];
    inc = ptr + 5'h01;
    next_ptr = ptr;
    // reserved codes leave the pointer alone rather than wander
    case (ctl[`LDA_CTL_MODE])
      `LDA_MODE_ALL: begin
        next_ptr = (ptr == `LDA_PTR_LAST) ? `LDA_PTR_ZERO : inc;
      end
      `LDA_MODE_BRIGHT: begin
        next_ptr = (ptr == `LDA_PTR_BRIGHT_LAST) ? `LDA_PTR_BRIGHT_FIRST : inc;
      end
      `LDA_MODE_GCTL: begin
        next_ptr = (ptr == `LDA_PTR_GCTL_LAST) ? `LDA_PTR_GCTL_FIRST : inc;
      end
      `LDA_MODE_BOTH: begin
        next_ptr = (ptr == `LDA_PTR_GCTL_LAST) ? `LDA_PTR_BRIGHT_FIRST : inc;
      end
      default: begin
        next_ptr = ptr;
      end
    endcase
  end
endmodule : lda_ptr_step
`default_nettype wire
